// ==== mce_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mce_defines.svh"
// Function
// R01 - open-load enable at index 180Bh, bit 4 input A, bits 3..0 inputs 3..0
// R02 - open-load bits reset to zero; writing zero turns detection off
// R03 - reserved bits of every register always read as zero
// R04 - buffer enable at index 180Ch, bit 1 core supply buffer, resets on
// R05 - bit 0 aux supply buffer, resets on, zero disables it
// R06 - cell check enable at index 1810h, sixteen bits, reset zero
// R07 - enabled cells take part in limit checks, disabled cells excluded
// R08 - writes to reserved bits have no effect
module mce_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // enables to analog blocks
  output mce_pkg::mce_enables_t enables,
  // cell limit checks
  input wire mce_pkg::mce_limits_t cell_raw,
  output mce_pkg::mce_limits_t cell_flag
);
  logic [`MCE_OL_W-1:0] ol_reg;
  logic [`MCE_OL_W-1:0] ol_next;
  logic [`MCE_BUF_W-1:0] buf_reg;
  logic [`MCE_BUF_W-1:0] buf_next;
  logic [`MCE_CELL_W-1:0] cell_reg;
  logic [`MCE_CELL_W-1:0] cell_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic hit_ol;
  logic hit_buf;
  logic hit_cell;
  logic wr_en;
  logic rd_setup;
  // aliases of single enable bits
  logic input_a_open_load_on;
  logic core_supply_buffer_on;
  logic aux_supply_buffer_on;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign hit_ol = (paddr == `MCE_OL_ADDR);
  assign hit_buf = (paddr == `MCE_BUF_ADDR);
  assign hit_cell = (paddr == `MCE_CELL_ADDR);
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ol | hit_buf | hit_cell);

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_comb
  begin
    ol_next = ol_reg;
    buf_next = buf_reg;
    cell_next = cell_reg;
    // R01 - open-load write
    // R08 - only defined bits stored
    if (wr_en && hit_ol)
      ol_next = pwdata[`MCE_OL_W-1:0];
    // R04 - buffer write
    // R05 - aux buffer bit
    if (wr_en && hit_buf)
      buf_next = pwdata[`MCE_BUF_W-1:0];
    // R06 - cell enable write
    if (wr_en && hit_cell)
      cell_next = pwdata[`MCE_CELL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    // R02 - reset values
    if (!presetn)
    begin
      ol_reg <= `MCE_OL_RST;
      buf_reg <= `MCE_BUF_RST;
      cell_reg <= `MCE_CELL_RST;
    end
    else
    begin
      ol_reg <= ol_next;
      buf_reg <= buf_next;
      cell_reg <= cell_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle
  always_comb
  begin
    rdata_next = rdata_reg;
    // R03 - upper bits zero
    if (rd_setup)
    begin
      rdata_next = 32'h0000_0000;
      if (hit_ol)
        rdata_next[`MCE_OL_W-1:0] = ol_reg;
      if (hit_buf)
        rdata_next[`MCE_BUF_W-1:0] = buf_reg;
      if (hit_cell)
        rdata_next[`MCE_CELL_W-1:0] = cell_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  assign prdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign enables.open_load_on = ol_reg;
  assign enables.buffer_on = buf_reg;
  assign enables.cell_check_on = cell_reg;
  // named enable bits
  assign input_a_open_load_on = ol_reg[`MCE_OL_INPUT_A_BIT];
  assign core_supply_buffer_on = buf_reg[`MCE_BUF_CORE_BIT];
  assign aux_supply_buffer_on = buf_reg[`MCE_BUF_AUX_BIT];

  // R07 - cell check gating
  mce_cell_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .cell_on(cell_reg),
    .raw(cell_raw),
    .flag(cell_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ol_write_store: assert property (@(posedge pclk) disable iff (!presetn) // R01
    (wr_en && hit_ol) |=> (enables.open_load_on == $past(pwdata[4:0])))
    else $error("open-load write not stored");
  a_ol_reset_zero: assert property (@(posedge pclk) // R02
    $rose(presetn) |-> (enables.open_load_on == 5'h00))
    else $error("open-load enables not zero after reset");
  a_rsv_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (rd_setup && hit_ol) ##1 (psel && penable) |-> (prdata[31:5] == 27'h0000000))
    else $error("reserved open-load bits read nonzero");
  a_buf_reset_on: assert property (@(posedge pclk) // R04
    $rose(presetn) |-> (enables.buffer_on == 2'h3))
    else $error("buffers not on after reset");
  a_buf_write_store: assert property (@(posedge pclk) disable iff (!presetn) // R05
    (wr_en && hit_buf) |=> (enables.buffer_on == $past(pwdata[1:0])))
    else $error("buffer write not stored");
  a_cell_read_back: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (rd_setup && hit_cell) |=> (prdata == {16'h0000, $past(cell_reg)}))
    else $error("cell enable read mismatch");
  a_cell_hold: assert property (@(posedge pclk) disable iff (!presetn) // R06
    !(wr_en && hit_cell) |=> $stable(enables.cell_check_on))
    else $error("cell enables changed without write");
  a_rsv_write_none: assert property (@(posedge pclk) disable iff (!presetn) // R08
    !(wr_en && (hit_ol || hit_buf)) |=> $stable(enables.open_load_on) && $stable(enables.buffer_on))
    else $error("enable bits changed without write");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !hit_ol && !hit_buf && !hit_cell) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // read-back and reserved bits
  a_ol_read_back: assert property (@(posedge pclk) disable iff (!presetn) // R01
    (rd_setup && hit_ol) |=> (prdata == {27'h0000000, $past(ol_reg)}))
    else $error("open-load read mismatch");
  a_buf_read_back: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (rd_setup && hit_buf) |=> (prdata == {30'h00000000, $past(buf_reg)}))
    else $error("buffer enable read mismatch");
  a_buf_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (rd_setup && hit_buf) |=> (prdata[31:2] == 30'h00000000))
    else $error("reserved buffer bits read nonzero");
  a_cell_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (rd_setup && hit_cell) |=> (prdata[31:16] == 16'h0000))
    else $error("reserved cell bits read nonzero");

  // write effects and reset
  a_ol_clear_off: assert property (@(posedge pclk) disable iff (!presetn) // R02
    (wr_en && hit_ol && !pwdata[`MCE_OL_INPUT_A_BIT]) |=> !input_a_open_load_on)
    else $error("open-load input a not turned off");
  a_core_buf_write: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (wr_en && hit_buf) |=> (core_supply_buffer_on == $past(pwdata[`MCE_BUF_CORE_BIT])))
    else $error("core supply buffer write not stored");
  a_aux_buf_off: assert property (@(posedge pclk) disable iff (!presetn) // R05
    (wr_en && hit_buf && !pwdata[`MCE_BUF_AUX_BIT]) |=> !aux_supply_buffer_on)
    else $error("aux supply buffer not disabled");
  a_cell_write_store: assert property (@(posedge pclk) disable iff (!presetn) // R06
    (wr_en && hit_cell) |=> (enables.cell_check_on == $past(pwdata[15:0])))
    else $error("cell enable write not stored");
  a_cell_reset_zero: assert property (@(posedge pclk) // R06
    $rose(presetn) |-> (enables.cell_check_on == 16'h0000))
    else $error("cell enables not zero after reset");

  // bus response
  a_unmapped_rd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && !hit_ol && !hit_buf && !hit_cell) |=> (prdata == 32'h0000_0000))
    else $error("unmapped read not zero");
  a_read_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_setup |=> $stable(prdata))
    else $error("read data changed outside read setup");
  a_err_access_only: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |-> !pslverr)
    else $error("error flagged outside access phase");

  // scenario covers
  c_ol_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_ol);
  c_unmapped_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_buf_off: cover property (@(posedge pclk) disable iff (!presetn) enables.buffer_on == 2'h0);
  c_cell_read: cover property (@(posedge pclk) disable iff (!presetn) rd_setup && hit_cell);
endmodule
`default_nettype wire

// ==== mce_defines.svh ====
`ifndef MCE_DEFINES_SVH
`define MCE_DEFINES_SVH
// register indices, byte address is four times the index
`define MCE_OL_IDX 16'h180b
`define MCE_BUF_IDX 16'h180c
`define MCE_CELL_IDX 16'h1810
`define MCE_OL_ADDR 16'h602c
`define MCE_BUF_ADDR 16'h6030
`define MCE_CELL_ADDR 16'h6040
// field widths
`define MCE_OL_W 5
`define MCE_BUF_W 2
`define MCE_CELL_W 16
// field positions
`define MCE_OL_INPUT_A_BIT 4
`define MCE_BUF_CORE_BIT 1
`define MCE_BUF_AUX_BIT 0
// reset values
`define MCE_OL_RST 5'h00
`define MCE_BUF_RST 2'h3
`define MCE_CELL_RST 16'h0000
`endif

// ==== mce_pkg.sv ====
`default_nettype none
package mce_pkg;
  // enables driven to the analog front end and checkers
  typedef struct packed {
    logic [4:0] open_load_on;
    logic [1:0] buffer_on;
    logic [15:0] cell_check_on;
  } mce_enables_t;
  // per-cell comparator results
  typedef struct packed {
    logic [15:0] over;
    logic [15:0] under;
  } mce_limits_t;
endpackage
`default_nettype wire

// ==== mce_cell_gate.sv ====
`timescale 1ns/1ns
`default_nettype none
module mce_cell_gate (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // enables and raw comparator results
  input wire logic [15:0] cell_on,
  input wire mce_pkg::mce_limits_t raw,
  // gated results
  output mce_pkg::mce_limits_t flag
);
  mce_pkg::mce_limits_t flag_reg;
  mce_pkg::mce_limits_t flag_next;

  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_cell
      // R07 - mask per channel
      always_comb
      begin
        flag_next.over[i] = raw.over[i] & cell_on[i];
        flag_next.under[i] = raw.under[i] & cell_on[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  assign flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_gate_mask: assert property (@(posedge pclk) disable iff (!presetn) // R07
    ##1 flag == mce_pkg::mce_limits_t'({$past(raw.over & cell_on), $past(raw.under & cell_on)}))
    else $error("cell limit flag not masked by enable");
  c_gate_flag: cover property (@(posedge pclk) disable iff (!presetn) flag.over != 16'h0000);
endmodule
`default_nettype wire

// ==== mce_regs_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mce_defines.svh"
module mce_regs_tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  mce_pkg::mce_enables_t enables;
  mce_pkg::mce_limits_t cell_raw = 32'h0;
  mce_pkg::mce_limits_t cell_flag;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] raw;
  int waits = 0;
  logic [31:0] sh [3];
  logic [31:0] m [3] = '{32'h1f, 32'h3, 32'hffff};
  logic [15:0] a [3] = '{`MCE_OL_ADDR, `MCE_BUF_ADDR, `MCE_CELL_ADDR};
  mce_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enables(enables), .cell_raw(cell_raw),
    .cell_flag(cell_flag));
  always #25 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    waits = 0;
    do
    begin
      @(posedge pclk);
      waits++;
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // value a register keeps after a write
  function automatic logic [31:0] stored_value(input int i, input logic [31:0] d);
    return d & m[i];
  endfunction
  // limit results after per-cell gating
  function automatic logic [31:0] gated(input logic [31:0] r, input logic [15:0] on);
    return r & {on, on};
  endfunction
  task automatic wr_reg(input int i, input logic [31:0] d);
    apb(1'h1, a[i], d);
    sh[i] = stored_value(i, d);
  endtask
  task automatic verify;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'h0, a[i], 32'h0);
      check("prdata", rd, sh[i]);
      check("pslverr", {31'h0, err}, 32'h0);
      check("wait_states", waits, 32'h1);
    end
    check("enables", {9'h0, enables}, {sh[0][4:0], sh[1][1:0], sh[2][15:0]});
  endtask
  task automatic cell_gate;
    @(posedge pclk);
    cell_raw <= $urandom;
    @(negedge pclk);
    raw = cell_raw;
    @(negedge pclk);
    check("cell_flag", cell_flag, gated(raw, sh[2][15:0]));
  endtask
  task automatic do_reset;
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    sh = '{32'h0, {30'h0, `MCE_BUF_RST}, 32'h0};
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h78ad6d56));
    do_reset();
    verify();
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(i, 32'hffffffff);
      verify();
      cell_gate();
      wr_reg(i, 32'h0);
      verify();
      cell_gate();
    end
    repeat (40)
    begin
      wr_reg($urandom_range(2), $urandom);
      verify();
      cell_gate();
    end
    // unmapped and misaligned places
    foreach (a[i])
    begin
      apb(1'h1, a[i] + 16'h1, 32'hffffffff);
      check("pslverr", {31'h0, err}, 32'h1);
      apb(1'h0, a[i] + 16'h2, 32'h0);
      check("prdata", rd, 32'h0);
    end
    apb(1'h1, 16'h6034, 32'hffffffff);
    verify();
    do_reset();
    verify();
    finish_test();
  end
  initial
  begin
    #(50 * 20000);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
